// ### rtl/host_chan_status_consts.svh
// Offsets, field positions, codes and reset values of the host channel status block
`ifndef HOST_CHAN_STATUS_CONSTS_SVH
`define HOST_CHAN_STATUS_CONSTS_SVH

// Register indices as printed; byte address is four times the index
`define SUMMARY_INDEX 12'h144
`define CONTROL_INDEX 12'h145
`define SUMMARY_ADDR 12'h510
`define CONTROL_ADDR 12'h514
`define STAGE_ADDR 12'h600
`define STATUS_RESET 8'h00
`define READ_UNMAPPED 32'h00000000

// Control channel status bit positions
`define BIT_TOTAL_SIZE 7
`define BIT_TRAN_ACK 6
`define BIT_TRAN_ERR 5
`define BIT_COND_CHANGE 4
`define BIT_SUPPORT_CMP 1
`define BIT_SUPPORT_STOP 0
`define CONTROL_IMPL_MASK 8'hF3
`define SUMMARY_IMPL_MASK 8'h1F

// Condition codes
`define CC_NO_ERROR 3'h0
`define CC_STALL 3'h1
`define CC_OVERRUN 3'h2
`define CC_UNDERRUN 3'h3
`define CC_RETRY 3'h4

`define RETRY_LIMIT 2'h3

`endif

// ### rtl/host_chan_status_pkg.sv
// Types shared by the host channel status block
package host_chan_status_pkg;

  typedef enum logic [1:0] {
    STAGE_SETUP,
    STAGE_DATA,
    STAGE_STATUS,
    STAGE_IDLE
  } stage_t;

endpackage

// ### rtl/condition_classifier.sv
// Classifies one finished transaction into a condition code
`include "host_chan_status_consts.svh"

module condition_classifier (
  // Transaction outcome
  input wire logic stall_i,
  input wire logic timeout_i,
  input wire logic crc_err_i,
  input wire logic stuff_err_i,
  input wire logic pid_err_i,
  input wire logic toggle_err_i,
  input wire logic pkt_over_max_i,
  input wire logic total_over_size_i,
  input wire logic short_pkt_i,
  input wire logic total_below_size_i,
  // Result
  output logic [2:0] code_o,
  output logic retry_o
);

  logic line_err;
  logic overrun;
  logic underrun;

  always_comb begin
    line_err = crc_err_i | stuff_err_i;
    // Short packet with bad toggle is a toggle mismatch, not overrun
    overrun = (pkt_over_max_i | total_over_size_i) & ~(short_pkt_i & toggle_err_i);
    underrun = short_pkt_i & total_below_size_i;
    retry_o = timeout_i | line_err | pid_err_i | toggle_err_i;
    if (retry_o) begin
      code_o = `CC_RETRY;
    end else if (stall_i) begin
      code_o = `CC_STALL;
    end else if (overrun) begin
      code_o = `CC_OVERRUN;
    end else if (underrun) begin
      code_o = `CC_UNDERRUN;
    end else begin
      code_o = `CC_NO_ERROR;
    end
  end

endmodule // condition_classifier

// ### rtl/host_channel_interrupt_status.sv
// Host channel summary status and control channel event status registers
`include "host_chan_status_consts.svh"

module host_channel_interrupt_status (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Avalon-MM slave
  input wire logic [11:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Other channels: status and enables, e down to a
  input wire logic [7:0] CHAN_E_STATUS_I,
  input wire logic [7:0] CHAN_D_STATUS_I,
  input wire logic [7:0] CHAN_C_STATUS_I,
  input wire logic [7:0] CHAN_B_STATUS_I,
  input wire logic [7:0] CHAN_A_STATUS_I,
  input wire logic [7:0] CHAN_E_ENABLES_I,
  input wire logic [7:0] CHAN_D_ENABLES_I,
  input wire logic [7:0] CHAN_C_ENABLES_I,
  input wire logic [7:0] CHAN_B_ENABLES_I,
  input wire logic [7:0] CHAN_A_ENABLES_I,
  // Control channel transaction engine
  input wire logic TRAN_DONE_I,
  input wire logic STALL_I,
  input wire logic TIMEOUT_I,
  input wire logic CRC_ERR_I,
  input wire logic STUFF_ERR_I,
  input wire logic PID_ERR_I,
  input wire logic TOGGLE_ERR_I,
  input wire logic PKT_OVER_MAX_I,
  input wire logic TOTAL_OVER_SIZE_I,
  input wire logic SHORT_PKT_I,
  input wire logic TOTAL_BELOW_SIZE_I,
  input wire logic TRANSFER_DONE_I,
  input wire logic [7:0] ACK_COUNT_I,
  // Control support function
  input wire logic CONTROL_SUPPORT_GO_I,
  input wire logic [1:0] STAGE_I,
  input wire logic STAGE_DONE_I,
  input wire logic STOP_DONE_I,
  input wire logic TRANSFER_GO_I,
  // Status out
  output logic [2:0] CONDITION_CODE_A_O,
  output logic [7:0] SUMMARY_O,
  output logic [7:0] CONTROL_STATUS_O
);

  logic [7:0] control_status;
  logic [7:0] summary;
  logic [7:0] next_summary;
  logic [7:0] set_bits;
  logic [7:0] clear_bits;
  logic [2:0] code;
  logic retry;
  logic [1:0] retry_run;
  logic [7:0] ack_done;
  logic transfer_go_q;
  logic support_go_q;
  logic status_stage_ok;
  logic wait_state;
  logic [2:0] cond_code;
  logic write_hit;
  logic [2:0] last_code;
  host_chan_status_pkg::stage_t stage;

  function automatic logic pending(input logic [7:0] st, input logic [7:0] en);
    pending = |(st & en);
  endfunction

  condition_classifier u_classifier (
    .stall_i(STALL_I),
    .timeout_i(TIMEOUT_I),
    .crc_err_i(CRC_ERR_I),
    .stuff_err_i(STUFF_ERR_I),
    .pid_err_i(PID_ERR_I),
    .toggle_err_i(TOGGLE_ERR_I),
    .pkt_over_max_i(PKT_OVER_MAX_I),
    .total_over_size_i(TOTAL_OVER_SIZE_I),
    .short_pkt_i(SHORT_PKT_I),
    .total_below_size_i(TOTAL_BELOW_SIZE_I),
    .code_o(code),
    .retry_o(retry)
  );

  always_comb begin
    stage = host_chan_status_pkg::stage_t'(STAGE_I);
    // Outcome lines carry meaning only with the done pulse; otherwise use the held code
    last_code = TRAN_DONE_I ? code : cond_code;
  end

  // Summary, recomputed each cycle from channel state
  always_comb begin
    next_summary = 8'h00;
    next_summary[4] = pending(CHAN_E_STATUS_I, CHAN_E_ENABLES_I);
    next_summary[3] = pending(CHAN_D_STATUS_I, CHAN_D_ENABLES_I);
    next_summary[2] = pending(CHAN_C_STATUS_I, CHAN_C_ENABLES_I);
    next_summary[1] = pending(CHAN_B_STATUS_I, CHAN_B_ENABLES_I);
    next_summary[0] = pending(CHAN_A_STATUS_I, CHAN_A_ENABLES_I);
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      summary <= `STATUS_RESET;
    end else begin
      summary <= next_summary;
    end
  end

  // Retry run length and acknowledged count within the current transfer
  always_ff @(posedge CLK_I) begin
    if (RESET_I || !TRANSFER_GO_I) begin
      retry_run <= 2'h0;
      ack_done <= 8'h00;
    end else if (TRAN_DONE_I) begin
      retry_run <= retry ? ((retry_run == `RETRY_LIMIT) ? 2'h1 : retry_run + 2'h1) : 2'h0;
      if (code == `CC_NO_ERROR && (!CONTROL_SUPPORT_GO_I || stage == host_chan_status_pkg::STAGE_DATA)) begin
        ack_done <= (ack_done + 8'h01 == ACK_COUNT_I) ? 8'h00 : ack_done + 8'h01;
      end
    end
  end

  // Edges of firmware go bits and status stage outcome
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      transfer_go_q <= 1'b0;
      support_go_q <= 1'b0;
      status_stage_ok <= 1'b0;
      wait_state <= 1'b0;
    end else begin
      transfer_go_q <= TRANSFER_GO_I;
      support_go_q <= CONTROL_SUPPORT_GO_I;
      if (STAGE_DONE_I && stage == host_chan_status_pkg::STAGE_STATUS) begin
        status_stage_ok <= (last_code == `CC_NO_ERROR);
      end else if (CONTROL_SUPPORT_GO_I && !support_go_q) begin
        status_stage_ok <= 1'b0;
      end
      if (support_go_q && !CONTROL_SUPPORT_GO_I) begin
        wait_state <= 1'b1;
      end else if (STOP_DONE_I) begin
        wait_state <= 1'b0;
      end
    end
  end

  // Events that set control channel flags
  always_comb begin
    set_bits = 8'h00;
    if (CONTROL_SUPPORT_GO_I) begin
      set_bits[`BIT_TOTAL_SIZE] = STAGE_DONE_I && stage == host_chan_status_pkg::STAGE_STATUS
                                  && last_code == `CC_NO_ERROR;
      set_bits[`BIT_SUPPORT_CMP] = set_bits[`BIT_TOTAL_SIZE];
      set_bits[`BIT_SUPPORT_STOP] = TRAN_DONE_I && code != `CC_NO_ERROR
                                    && (code == `CC_STALL || retry_run == 2'h2 && retry);
    end else begin
      set_bits[`BIT_TOTAL_SIZE] = TRANSFER_DONE_I;
    end
    if (wait_state && STOP_DONE_I) begin
      set_bits[`BIT_SUPPORT_CMP] = set_bits[`BIT_SUPPORT_CMP] | status_stage_ok;
      set_bits[`BIT_SUPPORT_STOP] = set_bits[`BIT_SUPPORT_STOP] | !status_stage_ok;
    end
    set_bits[`BIT_TRAN_ACK] = TRAN_DONE_I && code == `CC_NO_ERROR && ack_done + 8'h01 == ACK_COUNT_I
                              && (!CONTROL_SUPPORT_GO_I || stage == host_chan_status_pkg::STAGE_DATA);
    set_bits[`BIT_TRAN_ERR] = TRAN_DONE_I && retry;
    set_bits[`BIT_COND_CHANGE] = (TRAN_DONE_I && (code == `CC_STALL || code == `CC_OVERRUN
                                  || code == `CC_UNDERRUN || (retry && retry_run == 2'h2)))
                                 || (transfer_go_q && !TRANSFER_GO_I);
  end

  always_comb begin
    write_hit = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `CONTROL_ADDR
                && AVS_BYTEENABLE_I[0];
    clear_bits = write_hit ? (AVS_WRITEDATA_I[7:0] & `CONTROL_IMPL_MASK) : 8'h00;
  end

  // Set wins over a clear in the same cycle; flags hold until cleared
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      control_status <= `STATUS_RESET;
    end else begin
      control_status <= ((control_status & ~clear_bits) | set_bits) & `CONTROL_IMPL_MASK;
    end
  end

  // Last transaction's outcome is held for firmware
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      cond_code <= `CC_NO_ERROR;
    end else if (TRAN_DONE_I) begin
      cond_code <= code;
    end
  end

  // Avalon slave: one wait cycle, answer on the second edge
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= `READ_UNMAPPED;
    end else begin
      AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
      if (AVS_READ_I && AVS_WAITREQUEST_O) begin
        case (AVS_ADDRESS_I)
          `SUMMARY_ADDR: AVS_READDATA_O <= {24'h000000, summary};
          `CONTROL_ADDR: AVS_READDATA_O <= {24'h000000, control_status};
          `STAGE_ADDR: AVS_READDATA_O <= {29'h0, cond_code};
          default: AVS_READDATA_O <= `READ_UNMAPPED;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      CONDITION_CODE_A_O <= `CC_NO_ERROR;
      SUMMARY_O <= `STATUS_RESET;
      CONTROL_STATUS_O <= `STATUS_RESET;
    end else begin
      CONDITION_CODE_A_O <= cond_code;
      SUMMARY_O <= summary;
      CONTROL_STATUS_O <= control_status;
    end
  end

  AST_SUMMARY_TRACKS: assert property (@(posedge CLK_I) disable iff (RESET_I)
    ##1 summary[0] == $past(|(CHAN_A_STATUS_I & CHAN_A_ENABLES_I))
        && summary[4] == $past(|(CHAN_E_STATUS_I & CHAN_E_ENABLES_I)))
    else $error("summary does not follow enabled pending causes");
  AST_SUMMARY_RESERVED: assert property (@(posedge CLK_I) disable iff (RESET_I)
    summary[7:5] == 3'h0)
    else $error("summary reserved bits nonzero");
  AST_CLEAR_W1C: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (clear_bits[`BIT_TRAN_ERR] && !set_bits[`BIT_TRAN_ERR]) |=> !control_status[`BIT_TRAN_ERR])
    else $error("write one did not clear flag");
  AST_HOLD: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (control_status[`BIT_COND_CHANGE] && !clear_bits[`BIT_COND_CHANGE]) |=> control_status[`BIT_COND_CHANGE])
    else $error("flag dropped without clear");
  AST_RETRY_SETS_ERR: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && retry) |=> control_status[`BIT_TRAN_ERR])
    else $error("retry error did not set transaction error");
  AST_GO_CLEAR: assert property (@(posedge CLK_I) disable iff (RESET_I)
    ($fell(TRANSFER_GO_I)) |=> control_status[`BIT_COND_CHANGE])
    else $error("go clear did not set condition change");
  AST_RESERVED_ZERO: assert property (@(posedge CLK_I) disable iff (RESET_I)
    control_status[3:2] == 2'h0)
    else $error("control reserved bits nonzero");
  AST_RETRY_CODE: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && (CRC_ERR_I || STUFF_ERR_I)) |=> cond_code == `CC_RETRY)
    else $error("line error not coded as retry");
  AST_NO_ACK_SETUP: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CONTROL_SUPPORT_GO_I && stage != host_chan_status_pkg::STAGE_DATA) |-> !set_bits[`BIT_TRAN_ACK])
    else $error("ack flagged outside data stage");
  AST_WAIT_ONE: assert property (@(posedge CLK_I) disable iff (RESET_I)
    ($rose(AVS_READ_I) && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
    else $error("waitrequest not released after one cycle");

  // Summary bit positions
  AST_SUMMARY_MAP_B: assert property (@(posedge CLK_I) disable iff (RESET_I)
    ##1 summary[1] == $past(|(CHAN_B_STATUS_I & CHAN_B_ENABLES_I)))
    else $error("channel b summary bit misplaced");
  AST_SUMMARY_MAP_C: assert property (@(posedge CLK_I) disable iff (RESET_I)
    ##1 summary[2] == $past(|(CHAN_C_STATUS_I & CHAN_C_ENABLES_I)))
    else $error("channel c summary bit misplaced");
  AST_SUMMARY_MAP_D: assert property (@(posedge CLK_I) disable iff (RESET_I)
    ##1 summary[3] == $past(|(CHAN_D_STATUS_I & CHAN_D_ENABLES_I)))
    else $error("channel d summary bit misplaced");

  // Setting and keeping control channel flags
  AST_TOTAL_PLAIN: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (!CONTROL_SUPPORT_GO_I && TRANSFER_DONE_I) |=> control_status[`BIT_TOTAL_SIZE])
    else $error("finished transfer did not set total size complete");
  AST_TOTAL_ONLY_STATUS: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CONTROL_SUPPORT_GO_I && !STAGE_DONE_I && !control_status[`BIT_TOTAL_SIZE])
      |=> !control_status[`BIT_TOTAL_SIZE])
    else $error("total size complete set before the status stage ended");
  AST_SUPPORT_ALL_STAGES: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CONTROL_SUPPORT_GO_I && STAGE_DONE_I && stage == host_chan_status_pkg::STAGE_STATUS
      && last_code == `CC_NO_ERROR) |=> control_status[`BIT_SUPPORT_CMP])
    else $error("normal status stage did not set support complete");
  AST_ACK_COUNT_REACHED: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && code == `CC_NO_ERROR && !CONTROL_SUPPORT_GO_I
      && ack_done + 8'h01 == ACK_COUNT_I) |=> control_status[`BIT_TRAN_ACK])
    else $error("ack count reached without transaction acknowledged");
  AST_ACK_NOT_ON_ERROR: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && code != `CC_NO_ERROR && !control_status[`BIT_TRAN_ACK])
      |=> !control_status[`BIT_TRAN_ACK])
    else $error("failed transaction set transaction acknowledged");
  AST_STALL_CONDITION: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && STALL_I && !retry) |=> control_status[`BIT_COND_CHANGE])
    else $error("stall did not set condition change");
  AST_THIRD_RETRY: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && retry && retry_run == 2'h2) |=> control_status[`BIT_COND_CHANGE])
    else $error("third retry did not set condition change");
  AST_WRITE_ZERO_KEEPS: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (write_hit && !AVS_WRITEDATA_I[`BIT_TRAN_ERR] && control_status[`BIT_TRAN_ERR])
      |=> control_status[`BIT_TRAN_ERR])
    else $error("writing zero cleared a flag");

  // Condition code classification
  AST_CODE_NORMAL: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && !retry && !STALL_I && !PKT_OVER_MAX_I && !TOTAL_OVER_SIZE_I
      && !SHORT_PKT_I) |=> cond_code == `CC_NO_ERROR)
    else $error("clean transaction not coded as normal");
  AST_CODE_STALL: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && STALL_I && !retry) |=> cond_code == `CC_STALL)
    else $error("stall not coded as stall");
  AST_CODE_OVERRUN: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && !retry && !STALL_I && (PKT_OVER_MAX_I || TOTAL_OVER_SIZE_I))
      |=> cond_code == `CC_OVERRUN)
    else $error("oversize data not coded as overrun");
  AST_TOGGLE_SHORT: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && SHORT_PKT_I && TOGGLE_ERR_I) |=> cond_code == `CC_RETRY)
    else $error("short packet with bad toggle not coded as retry");
  AST_CODE_UNDERRUN: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && !retry && !STALL_I && !PKT_OVER_MAX_I && !TOTAL_OVER_SIZE_I
      && SHORT_PKT_I && TOTAL_BELOW_SIZE_I) |=> cond_code == `CC_UNDERRUN)
    else $error("early short packet not coded as underrun");
  AST_CODE_RETRY_CAUSES: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (TRAN_DONE_I && (TIMEOUT_I || PID_ERR_I || TOGGLE_ERR_I)) |=> cond_code == `CC_RETRY)
    else $error("timeout, pid or toggle error not coded as retry");

  // Support function completion and stop
  AST_STOP_GOOD_STATUS: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wait_state && STOP_DONE_I && status_stage_ok) |=> control_status[`BIT_SUPPORT_CMP])
    else $error("stop after good status stage did not set support complete");
  AST_STOP_BAD_STATUS: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wait_state && STOP_DONE_I && !status_stage_ok) |=> control_status[`BIT_SUPPORT_STOP])
    else $error("stop without good status stage did not set support stop");
  AST_SUPPORT_STALL_STOP: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CONTROL_SUPPORT_GO_I && TRAN_DONE_I && STALL_I && !retry)
      |=> control_status[`BIT_SUPPORT_STOP])
    else $error("stall under support did not set support stop");

endmodule // host_channel_interrupt_status

// ### sim/usb_endpoint_model.sv
// Behavioural endpoint model that drives control channel transaction outcomes
module usb_endpoint_model (
  // Clock
  input wire logic clk_i,
  // Command from the bench
  input wire logic fire_i,
  input wire logic [9:0] outcome_i,
  // Transaction outcome
  output logic done_o,
  output logic [9:0] outcome_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    done_o = 1'b0;
    outcome_o = 10'h000;
  end

  // Outcome lines mean something only with done; between pulses they toggle
  always @(posedge clk_i) begin
    done_o <= fire_i;
    outcome_o <= fire_i ? outcome_i : ~outcome_o;
  end
endmodule // usb_endpoint_model

// ### sim/tb_top.sv
// Self-checking bench for the host channel interrupt status block
`include "host_chan_status_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst, rd, we, wait_o, fire, tdone, sgo, sdone, stopd, tgo, done;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] cs [5];
  logic [7:0] ce [5];
  logic [7:0] ack, summ, ctl;
  logic [9:0] oc_in, oc;
  logic [1:0] stage;
  logic [2:0] code;
  int err_count, total_checks;
  // Outcome order: stall timeout crc stuff pid toggle pkt_over total_over short below
  localparam logic [9:0] KINDS [13] = '{10'h000, 10'h200, 10'h008, 10'h004, 10'h003,
    10'h100, 10'h080, 10'h040, 10'h020, 10'h010, 10'h088, 10'h043, 10'h012};
  localparam logic [2:0] CODES [13] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4,
    3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};

  usb_endpoint_model EP (.clk_i(clk), .fire_i(fire), .outcome_i(oc_in), .done_o(done),
    .outcome_o(oc));

  host_channel_interrupt_status DUT (.CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(we), .AVS_BYTEENABLE_I(4'hF), .AVS_WRITEDATA_I(wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_o),
    .CHAN_E_STATUS_I(cs[4]), .CHAN_D_STATUS_I(cs[3]), .CHAN_C_STATUS_I(cs[2]),
    .CHAN_B_STATUS_I(cs[1]), .CHAN_A_STATUS_I(cs[0]), .CHAN_E_ENABLES_I(ce[4]),
    .CHAN_D_ENABLES_I(ce[3]), .CHAN_C_ENABLES_I(ce[2]), .CHAN_B_ENABLES_I(ce[1]),
    .CHAN_A_ENABLES_I(ce[0]), .TRAN_DONE_I(done), .STALL_I(oc[9]), .TIMEOUT_I(oc[8]),
    .CRC_ERR_I(oc[7]), .STUFF_ERR_I(oc[6]), .PID_ERR_I(oc[5]), .TOGGLE_ERR_I(oc[4]),
    .PKT_OVER_MAX_I(oc[3]), .TOTAL_OVER_SIZE_I(oc[2]), .SHORT_PKT_I(oc[1]),
    .TOTAL_BELOW_SIZE_I(oc[0]), .TRANSFER_DONE_I(tdone), .ACK_COUNT_I(ack),
    .CONTROL_SUPPORT_GO_I(sgo), .STAGE_I(stage), .STAGE_DONE_I(sdone),
    .STOP_DONE_I(stopd), .TRANSFER_GO_I(tgo), .CONDITION_CODE_A_O(code),
    .SUMMARY_O(summ), .CONTROL_STATUS_O(ctl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    addr <= a;
    rd <= ~wr;
    we <= wr;
    wdata <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q & m, e);
  endtask

  task automatic clr(input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, `CONTROL_ADDR, d, q);
  endtask

  task automatic xact(input logic [9:0] o);
    fire <= 1'b1;
    oc_in <= o;
    @(posedge clk);
    fire <= 1'b0;
    tick(4);
  endtask

  task automatic pulse(input int k);
    case (k)
      0: tdone <= 1'b1;
      1: sdone <= 1'b1;
      default: stopd <= 1'b1;
    endcase
    @(posedge clk);
    tdone <= 1'b0;
    sdone <= 1'b0;
    stopd <= 1'b0;
    tick(3);
  endtask

  initial begin
    #1000000;
    err_count++;
    test_done;
  end

  initial begin
    {rst, rd, we, fire, tdone, sgo, sdone, stopd, tgo} = 9'h100;
    addr = 12'h000;
    wdata = 32'h00000000;
    oc_in = 10'h000;
    ack = 8'h01;
    stage = host_chan_status_pkg::STAGE_IDLE;
    err_count = 0;
    total_checks = 0;
    for (int i = 0; i < 5; i++) begin
      cs[i] = 8'h00;
      ce[i] = 8'h00;
    end
    tick(6);
    rst <= 1'b0;
    tgo <= 1'b1;
    @(posedge clk);
    rdc(`SUMMARY_ADDR, 32'hFFFFFFFF, 32'h00000000);
    rdc(`CONTROL_ADDR, 32'hFFFFFFFF, 32'h00000000);
    rdc(12'h7FC, 32'hFFFFFFFF, 32'h00000000);
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 5; j++) ce[j] <= 8'h7F;
      for (int j = 0; j < 5; j++) cs[j] <= (i == j) ? 8'h80 : 8'h00;
      tick(3);
      rdc(`SUMMARY_ADDR, 32'hFFFFFFFF, 32'h00000000);
      ce[i] <= 8'hFF;
      tick(3);
      clr(8'hFF);
      rdc(`SUMMARY_ADDR, 32'hFFFFFFFF, 32'h00000001 << i);
      check({24'h000000, summ}, 32'h00000001 << i);
    end
    for (int i = 0; i < 13; i++) begin
      xact(10'h000);
      clr(8'hFF);
      xact(KINDS[i]);
      check({29'h0, code}, {29'h0, CODES[i]});
      rdc(`CONTROL_ADDR, 32'h30, (CODES[i] == 3'h4) ? 32'h20 :
          (CODES[i] == 3'h0) ? 32'h00 : 32'h10);
      clr(8'hFF);
      rdc(`CONTROL_ADDR, 32'hFFFFFFFF, 32'h00000000);
    end
    xact(10'h000);
    clr(8'hFF);
    xact(10'h100);
    xact(10'h100);
    rdc(`CONTROL_ADDR, 32'h30, 32'h20);
    xact(10'h100);
    rdc(`CONTROL_ADDR, 32'h30, 32'h30);
    clr(8'h1C);
    rdc(`CONTROL_ADDR, 32'hFF, 32'h20);
    xact(10'h080);
    rdc(`CONTROL_ADDR, 32'hFF, 32'h20);
    clr(8'hFF);
    ack <= 8'h02;
    xact(10'h000);
    rdc(`CONTROL_ADDR, 32'hFF, 32'h00);
    xact(10'h000);
    rdc(`CONTROL_ADDR, 32'hFF, 32'h40);
    clr(8'hFF);
    pulse(0);
    rdc(`CONTROL_ADDR, 32'hFF, 32'h80);
    check({24'h000000, ctl}, 32'h00000080);
    tgo <= 1'b0;
    tick(4);
    rdc(`CONTROL_ADDR, 32'h10, 32'h10);
    clr(8'hFF);
    ack <= 8'h01;
    sgo <= 1'b1;
    stage <= host_chan_status_pkg::STAGE_SETUP;
    xact(10'h000);
    rdc(`CONTROL_ADDR, 32'h40, 32'h00);
    pulse(1);
    stage <= host_chan_status_pkg::STAGE_DATA;
    xact(10'h000);
    rdc(`CONTROL_ADDR, 32'h40, 32'h40);
    pulse(1);
    stage <= host_chan_status_pkg::STAGE_STATUS;
    xact(10'h000);
    rdc(`CONTROL_ADDR, 32'h80, 32'h00);
    pulse(1);
    rdc(`CONTROL_ADDR, 32'h83, 32'h82);
    clr(8'hFF);
    stage <= host_chan_status_pkg::STAGE_DATA;
    xact(10'h200);
    rdc(`CONTROL_ADDR, 32'h11, 32'h11);
    clr(8'hFF);
    stage <= host_chan_status_pkg::STAGE_STATUS;
    xact(10'h000);
    sgo <= 1'b0;
    @(posedge clk);
    pulse(2);
    rdc(`CONTROL_ADDR, 32'h03, 32'h02);
    test_done;
  end
endmodule // tb_top
